// *** scsr_control_status.sv ***
// Functional notes
// - volatile bits clear at power-up; nonvolatile bits keep stored values.
// - writes other than data 02 and 00 abort with no data acknowledge unless write enable is set and the data is 06 or unlock is set.
// - data 02 sets write enable, 00 clears it; a register write loads it from bit 1, else it stays.
// - write enable only writes start no store cycle; ready after stop.
// - other bits are written only while register unlock latch is set.
// - register unlock latch can be set only with write enable set.
// - unlock clears after register write, power-down or locked memory write.
// - lock field protects none, C0-FF, 80-FF or all; default none.
// - write to locked memory address aborts; contents unchanged.
// - nonzero lock field refuses potentiometer wiper writes.
// - write protect pin high blocks nonvolatile memory and nonvolatile pot writes.
// - reset delay field selects 50, 100, 200, 300 ms hold.
// - reset output high until supply stays good for hold time.
// - monitor flags power up 0; set only while fail output high.
// - set monitor flag clears when fail output low or power cycled.
// - slave address 1010010 and address byte FF select the register.
// - one data byte per write; a second is refused and aborts.
// - stop after the data byte starts the nonvolatile store, 5 ms.
// - byte layout: delay hi, flags, lock field, unlock latch, write enable, delay lo.
// - write protect high ignores nonvolatile register bit writes.
// - during a store cycle bus ignored and data line released.
`timescale 1ns/1ps
module scsr_control_status import scsr_pkg::*; #(
	parameter int NV_CYC = NV_CYCLE_CYC,
	parameter int HOLD_50 = HOLD_50_CYC,
	parameter int HOLD_100 = HOLD_100_CYC,
	parameter int HOLD_200 = HOLD_200_CYC,
	parameter int HOLD_300 = HOLD_300_CYC
) (
	// clock and resets
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic factory_init_i,
	// two-wire serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// pins
	input wire logic wp_i,
	input wire logic supply_ok_i,
	input wire logic mon2_fail_out_i,
	input wire logic mon3_fail_out_i,
	output logic rst_out_o,
	// memory and pot write permission
	input wire logic ee_wr_req_i,
	input wire logic [7:0] ee_wr_addr_i,
	input wire logic pot_wr_req_i,
	input wire logic pot_wr_nv_i,
	output logic ee_wr_ok_o,
	output logic pot_wr_ok_o,
	// state
	output logic [7:0] control_status_reg_o,
	output logic nv_busy_o
);

	// ==========================================================
	// pin synchronisers
	// only the second stage is read; the first may be metastable
	localparam int NPIN = 6;
	logic [NPIN-1:0] meta_r;
	logic [NPIN-1:0] sync_r;
	logic scl_d_r;
	logic sda_d_r;
	wire logic [NPIN-1:0] pins = {scl_i, sda_i, wp_i, supply_ok_i,
		mon2_fail_out_i, mon3_fail_out_i};

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			meta_r <= '1;
			sync_r <= '1;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			meta_r <= pins;
			sync_r <= meta_r;
			scl_d_r <= sync_r[5];
			sda_d_r <= sync_r[4];
		end
	end

	wire logic scl_s = sync_r[5];
	wire logic sda_s = sync_r[4];
	wire logic wp_s = sync_r[3];
	wire logic supply_s = sync_r[2];
	wire logic mon2_fail_s = sync_r[1];
	wire logic mon3_fail_s = sync_r[0];
	wire logic scl_rise = scl_s & ~scl_d_r;
	wire logic scl_fall = ~scl_s & scl_d_r;
	wire logic bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire logic bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// ==========================================================
	// nonvolatile cell
	scsr_nv_s nv_q;
	scsr_nv_s nv_wdata_r;
	logic nv_wr_r;
	logic nv_busy;

	scsr_nv_cell #(
		.NV_CYC(NV_CYC)
	) u_nv (
		.core_clk_i(core_clk_i),
		.factory_init_i(factory_init_i),
		.wr_i(nv_wr_r),
		.wr_data_i(nv_wdata_r),
		.nv_o(nv_q),
		.busy_o(nv_busy)
	);

	// ==========================================================
	// volatile latches
	logic write_enable_latch_r;
	logic register_write_unlock_r;
	logic mon2_flag_r;
	logic mon3_flag_r;

	// ==========================================================
	// serial receiver state
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_ADDR,
		ST_DATA,
		ST_EXTRA
	} scsr_st_e;

	scsr_st_e state_r;
	scsr_st_e next_st_r;
	logic [7:0] shift_r;
	logic [3:0] cnt_r;
	logic ack_r;
	logic oe_r;
	logic pend_r;
	scsr_act_e act_r;
	logic [7:0] data_r;

	wire logic byte_done = scl_fall & ~ack_r & (cnt_r == BITS_PER_BYTE);
	wire logic dev_hit = (shift_r[7:1] == CR_DEV_ADDR) & ~shift_r[0];
	wire logic addr_hit = (shift_r == CR_OFFSET);
	wire logic unlocked = write_enable_latch_r & register_write_unlock_r;

	// data byte decode
	scsr_act_e act_w;
	always_comb begin
		if (unlocked)
			act_w = shift_r[BIT_UNLOCK] ? ACT_UNLOCK_ONLY : ACT_FULL;
		else if (shift_r == DATA_WEL_SET)
			act_w = ACT_WEL_SET;
		else if (shift_r == DATA_WEL_CLR)
			act_w = ACT_WEL_CLR;
		else if (write_enable_latch_r && shift_r == DATA_UNLOCK)
			act_w = ACT_UNLOCK;
		else
			act_w = ACT_NONE;
	end

	wire logic data_ack = (act_w != ACT_NONE);

	// ack decision for the byte just completed
	logic give_ack;
	scsr_st_e after_ack;
	always_comb begin
		give_ack = 1'b0;
		after_ack = ST_IDLE;
		case (state_r)
			ST_DEV: begin
				give_ack = dev_hit;
				after_ack = ST_ADDR;
			end
			ST_ADDR: begin
				give_ack = addr_hit;
				after_ack = ST_DATA;
			end
			ST_DATA: begin
				give_ack = data_ack;
				after_ack = ST_EXTRA;
			end
			default: begin
				give_ack = 1'b0;
				after_ack = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// serial receiver
	// a store cycle freezes the receiver and releases the line
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || nv_busy) begin
			state_r <= ST_IDLE;
			next_st_r <= ST_IDLE;
			shift_r <= 8'h00;
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (bus_start) begin
			state_r <= ST_DEV;
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (bus_stop) begin
			state_r <= ST_IDLE;
			ack_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (state_r != ST_IDLE) begin
			if (scl_rise && !ack_r) begin
				shift_r <= {shift_r[6:0], sda_s};
				cnt_r <= cnt_r + 4'h1;
			end else if (byte_done) begin
				ack_r <= 1'b1;
				oe_r <= give_ack;
				next_st_r <= give_ack ? after_ack : ST_IDLE;
			end else if (scl_fall && ack_r) begin
				ack_r <= 1'b0;
				oe_r <= 1'b0;
				cnt_r <= 4'h0;
				state_r <= next_st_r;
			end
		end
	end

	// pending write: armed by an acked data byte, killed by a second
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || nv_busy || bus_start) begin
			pend_r <= 1'b0;
			act_r <= ACT_NONE;
			data_r <= 8'h00;
		end else if (byte_done && state_r == ST_DATA) begin
			pend_r <= data_ack;
			act_r <= act_w;
			data_r <= shift_r;
		end else if (byte_done && state_r == ST_EXTRA) begin
			pend_r <= 1'b0;
		end else if (bus_stop) begin
			pend_r <= 1'b0;
		end
	end

	// the stop's own scl rise shifts one bit; deeper or in ack cancels
	wire logic commit = bus_stop & pend_r & ~ack_r & (cnt_r <= 4'h1);

	// ==========================================================
	// memory and pot write permission
	logic ee_locked;
	always_comb begin
		case (nv_q.lock_field)
			LOCK_NONE: ee_locked = 1'b0;
			LOCK_QUARTER: ee_locked = (ee_wr_addr_i >= REGION_QUARTER);
			LOCK_HALF: ee_locked = (ee_wr_addr_i >= REGION_HALF);
			LOCK_ALL: ee_locked = 1'b1;
			default: ee_locked = 1'b1;
		endcase
	end

	// wp blocks the nonvolatile array and nonvolatile pot stores
	assign ee_wr_ok_o = ee_wr_req_i & write_enable_latch_r & ~ee_locked
		& ~wp_s & ~nv_busy;
	assign pot_wr_ok_o = pot_wr_req_i & write_enable_latch_r
		& (nv_q.lock_field == LOCK_NONE)
		& ~(pot_wr_nv_i & wp_s) & ~nv_busy;
	wire logic ee_lock_hit = ee_wr_req_i & ee_locked;

	// ==========================================================
	// register update
	wire logic full_wr = commit & (act_r == ACT_FULL);
	wire logic mon2_set = data_r[BIT_MON2] & mon2_fail_s;
	wire logic mon3_set = data_r[BIT_MON3] & mon3_fail_s;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			write_enable_latch_r <= 1'b0;
			register_write_unlock_r <= 1'b0;
		end else if (commit) begin
			case (act_r)
				ACT_WEL_SET: write_enable_latch_r <= 1'b1;
				ACT_WEL_CLR: write_enable_latch_r <= 1'b0;
				ACT_UNLOCK: register_write_unlock_r <= 1'b1;
				ACT_UNLOCK_ONLY: register_write_unlock_r <= 1'b1;
				ACT_FULL: begin
					write_enable_latch_r <= data_r[BIT_WEL];
					register_write_unlock_r <= 1'b0;
				end
				default: write_enable_latch_r <= write_enable_latch_r;
			endcase
		end else if (ee_lock_hit) begin
			register_write_unlock_r <= 1'b0;
		end
	end

	// flags follow their fail outputs down; a write sets only while high
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			mon2_flag_r <= 1'b0;
			mon3_flag_r <= 1'b0;
		end else if (full_wr) begin
			mon2_flag_r <= mon2_set;
			mon3_flag_r <= mon3_set;
		end else begin
			mon2_flag_r <= mon2_flag_r & mon2_fail_s;
			mon3_flag_r <= mon3_flag_r & mon3_fail_s;
		end
	end

	// store request for the nonvolatile fields
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			nv_wr_r <= 1'b0;
			nv_wdata_r <= NV_FACTORY;
		end else begin
			nv_wr_r <= full_wr & ~wp_s;
			nv_wdata_r <= '{reset_delay: {data_r[BIT_DLY_HI],
				data_r[BIT_DLY_LO]},
				lock_field: {data_r[BIT_LOCK_HI],
				data_r[BIT_LOCK_LO]}};
		end
	end

	// ==========================================================
	// power-on reset hold
	// counter restarts whenever the supply dips below the trip level
	logic [31:0] hold_sel;
	always_comb begin
		case (nv_q.reset_delay)
			DLY_50: hold_sel = 32'(HOLD_50);
			DLY_100: hold_sel = 32'(HOLD_100);
			DLY_200: hold_sel = 32'(HOLD_200);
			DLY_300: hold_sel = 32'(HOLD_300);
			default: hold_sel = 32'(HOLD_100);
		endcase
	end

	logic [31:0] hold_cnt_r;
	logic rst_out_r;
	wire logic hold_done = (hold_cnt_r >= hold_sel - 32'h1);

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !supply_s) begin
			hold_cnt_r <= 32'h0;
			rst_out_r <= 1'b1;
		end else if (hold_done) begin
			rst_out_r <= 1'b0;
		end else begin
			hold_cnt_r <= hold_cnt_r + 32'h1;
		end
	end

	// ==========================================================
	// readable state
	logic [7:0] cr_r;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i)
			cr_r <= 8'h00;
		else
			cr_r <= {nv_q.reset_delay[1], mon2_flag_r, mon3_flag_r,
				nv_q.lock_field, register_write_unlock_r,
				write_enable_latch_r, nv_q.reset_delay[0]};
	end

	assign control_status_reg_o = cr_r;
	assign nv_busy_o = nv_busy;
	assign rst_out_o = rst_out_r;
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_r & ~nv_busy;

endmodule // scsr_control_status

// *** scsr_control_status_properties.sv ***
`timescale 1ns/1ps
module scsr_control_status_properties #(
	parameter int NV_CYC = 50,
	parameter int HOLD_50 = 20
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// pins
	input wire logic sda_oe_o,
	input wire logic wp_i,
	input wire logic supply_ok_i,
	input wire logic mon2_fail_out_i,
	input wire logic mon3_fail_out_i,
	input wire logic rst_out_o,
	// permissions and state
	input wire logic ee_wr_req_i,
	input wire logic [7:0] ee_wr_addr_i,
	input wire logic pot_wr_req_i,
	input wire logic pot_wr_nv_i,
	input wire logic ee_wr_ok_o,
	input wire logic pot_wr_ok_o,
	input wire logic [7:0] control_status_reg_o,
	input wire logic nv_busy_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	int busy_cnt = 0;
	int sup_cnt = 0;
	wire [1:0] lk = control_status_reg_o[4:3];
	logic [7:0] addr_q;
	// image lags the live latches a cycle, so lock checks look one on
	wire lk_hit = lk == 2'h3 || lk == 2'h2 && addr_q[7]
		|| lk == 2'h1 && addr_q[7:6] == 2'h3;
	// raw counts run ahead of the synced ones in the design
	always_ff @(posedge core_clk_i) begin
		addr_q <= ee_wr_addr_i;
		busy_cnt <= nv_busy_o ? busy_cnt + 1 : 0;
		sup_cnt <= supply_ok_i ? sup_cnt + 1 : 0;
	end
	sequence s_store_end; $fell(nv_busy_o); endsequence
	sequence s_wp_held; wp_i [*5]; endsequence
	sequence s_sup_low; !supply_ok_i [*5]; endsequence

	AST_BUSY_QUIET: assert property (nv_busy_o |-> !sda_oe_o)
		else $error("data line pulled during store");
	AST_STORE_LEN: assert property (s_store_end |->
		busy_cnt >= NV_CYC - 1 && busy_cnt <= NV_CYC + 2)
		else $error("store cycle length wrong");
	AST_STORE_WP: assert property (s_wp_held |-> !$rose(nv_busy_o))
		else $error("store started under write protect");
	AST_EE_WP: assert property (s_wp_held |-> !ee_wr_ok_o)
		else $error("memory write allowed under write protect");
	AST_POT_WP: assert property ((s_wp_held ##0 pot_wr_nv_i)
		|-> !pot_wr_ok_o)
		else $error("pot store allowed under write protect");
	AST_EE_REQ: assert property (ee_wr_ok_o |-> ee_wr_req_i
		&& !nv_busy_o ##1 control_status_reg_o[1])
		else $error("memory write allowed without enable");
	AST_EE_LOCK: assert property (ee_wr_ok_o |=> !lk_hit)
		else $error("locked memory address allowed");
	AST_POT_LOCK: assert property (pot_wr_ok_o |-> pot_wr_req_i
		##1 lk == 2'h0)
		else $error("pot write allowed while locked");
	AST_FLAG_SET: assert property ($rose(control_status_reg_o[6])
		|-> mon2_fail_out_i)
		else $error("flag set without fail output");
	AST_FLAG_CLR: assert property (!mon3_fail_out_i [*6]
		|-> !control_status_reg_o[5])
		else $error("flag kept after fail output low");
	AST_HOLD: assert property ($fell(rst_out_o) |-> sup_cnt >= HOLD_50)
		else $error("reset released too early");
	AST_SUP_LOW: assert property (s_sup_low |-> rst_out_o)
		else $error("reset low with supply low");
endmodule // scsr_control_status_properties

bind scsr_control_status scsr_control_status_properties #(
	.NV_CYC(NV_CYC),
	.HOLD_50(HOLD_50)
) i_props (
	.core_clk_i(core_clk_i),
	.sys_rst_i(sys_rst_i),
	.sda_oe_o(sda_oe_o),
	.wp_i(wp_i),
	.supply_ok_i(supply_ok_i),
	.mon2_fail_out_i(mon2_fail_out_i),
	.mon3_fail_out_i(mon3_fail_out_i),
	.rst_out_o(rst_out_o),
	.ee_wr_req_i(ee_wr_req_i),
	.ee_wr_addr_i(ee_wr_addr_i),
	.pot_wr_req_i(pot_wr_req_i),
	.pot_wr_nv_i(pot_wr_nv_i),
	.ee_wr_ok_o(ee_wr_ok_o),
	.pot_wr_ok_o(pot_wr_ok_o),
	.control_status_reg_o(control_status_reg_o),
	.nv_busy_o(nv_busy_o)
);

// *** scsr_control_status_tb.sv ***
`timescale 1ns/1ps
module scsr_control_status_tb import scsr_pkg::*; ;
	// ==========================================================
	// signals and expected state
	localparam int NV = 400;
	logic clk = 0, rst = 1, fi = 1, wp = 0, sup = 1, f2 = 0, f3 = 0;
	logic eq = 0, pq = 0, pnv = 0, so, oe, ro, eok, pok, busy, scl, sda;
	logic [7:0] ea = 8'h00, img;
	logic write_enable_latch = 0, unl = 0, m2 = 0, m3 = 0;
	logic [1:0] lk = LOCK_NONE, dl = DLY_100;
	logic [3:0] a;
	int err_total = 0, n_compared = 0, seed = 74957;
	int hold [4] = '{20, 40, 60, 80};

	scsr_control_status #(.NV_CYC(NV), .HOLD_50(20), .HOLD_100(40),
		.HOLD_200(60), .HOLD_300(80)) i_dut (.core_clk_i(clk),
		.sys_rst_i(rst), .factory_init_i(fi), .scl_i(scl), .sda_i(sda),
		.sda_o(so), .sda_oe_o(oe), .wp_i(wp), .supply_ok_i(sup),
		.mon2_fail_out_i(f2), .mon3_fail_out_i(f3), .rst_out_o(ro),
		.ee_wr_req_i(eq), .ee_wr_addr_i(ea), .pot_wr_req_i(pq),
		.pot_wr_nv_i(pnv), .ee_wr_ok_o(eok), .pot_wr_ok_o(pok),
		.control_status_reg_o(img), .nv_busy_o(busy));
	scsr_host_model i_host (.dev_oe_i(oe), .dev_sda_i(so), .scl_o(scl),
		.sda_o(sda));
	initial forever #2.5 clk = ~clk;

	// ==========================================================
	// checking and expectations
	task chk(input string nm, input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	function logic [7:0] im();
		return {dl[1], m2, m3, lk, unl, write_enable_latch, dl[0]};
	endfunction
	function logic ee_exp(input logic [7:0] ad);
		return write_enable_latch && !wp && !(lk == LOCK_ALL || lk == LOCK_HALF && ad[7]
			|| lk == LOCK_QUARTER && ad[7:6] == 2'h3);
	endfunction

	task automatic cr(input logic [7:0] d);
		logic ak, st;
		logic [1:0] nl, nd;
		ak = 0;
		st = 0;
		nl = lk;
		nd = dl;
		m2 &= f2;
		m3 &= f3;
		if (write_enable_latch && unl) begin
			ak = 1;
			if (!d[BIT_UNLOCK]) begin
				write_enable_latch = d[BIT_WEL];
				unl = 0;
				m2 = d[BIT_MON2] & f2;
				m3 = d[BIT_MON3] & f3;
				st = !wp;
				nl = wp ? lk : d[4:3];
				nd = wp ? dl : {d[7], d[0]};
			end
		end else if (d == DATA_WEL_SET || d == DATA_WEL_CLR) begin
			ak = 1;
			write_enable_latch = d[BIT_WEL];
		end else if (d == DATA_UNLOCK && write_enable_latch) begin
			ak = 1;
			unl = 1;
		end
		i_host.xfer(CR_DEV_ADDR, CR_OFFSET, {d, 8'h00}, 1, a);
		chk("addr acks", 8'(a[3:2]), 8'h03);
		chk("data ack", 8'(a[1]), 8'(ak));
		chk("sda level", 8'(so), 8'h00);
		repeat (6) @(negedge clk);
		chk("busy", 8'(busy), 8'(st));
		chk("image", img, im());
		if (st) begin
			i_host.xfer(CR_DEV_ADDR, CR_OFFSET, 16'h0000, 1, a);
			chk("acks in store", 8'(a), 8'h00);
			repeat (NV) @(negedge clk);
			lk = nl;
			dl = nd;
			chk("stored", img, im());
		end
	endtask
	task bad(input logic [6:0] dv, input logic [7:0] ad, input int nd,
		input logic [3:0] ex);
		i_host.xfer(dv, ad, {DATA_WEL_SET, DATA_WEL_SET}, nd, a);
		chk("frame acks", 8'(a), 8'(ex));
		repeat (6) @(negedge clk);
		chk("frame image", img, im());
	endtask
	task hold_chk;
		@(negedge clk) sup = 0;
		repeat (8) @(negedge clk);
		chk("rst supply low", 8'(ro), 8'h01);
		sup = 1;
		repeat (hold[dl]) @(negedge clk);
		chk("rst held", 8'(ro), 8'h01);
		repeat (8) @(negedge clk);
		chk("rst freed", 8'(ro), 8'h00);
	endtask

	// ==========================================================
	// scenarios
	initial begin
		repeat (20) @(negedge clk);
		rst = 0;
		fi = 0;
		repeat (4) @(negedge clk);
		chk("power up", img, im());
		hold_chk();
		$display("test power up done");
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			wp = 1'($random(seed));
			f2 = 1'($random(seed));
			f3 = 1'($random(seed));
			i_host.lag = (i % 2) * 30;
			cr(8'($random(seed)));
			cr(DATA_WEL_SET);
			cr(DATA_UNLOCK);
			cr(8'($random(seed)));
		end
		$display("test random writes done");
		for (int k = 0; k < 4; k++) begin
			@(negedge clk) wp = 0;
			cr(DATA_WEL_SET);
			cr(DATA_UNLOCK);
			cr({k[1], 2'h0, 2'(k), 2'h1, k[0]});
			hold_chk();
			repeat (10) begin
				@(negedge clk);
				ea = 8'($random(seed));
				wp = 1'($random(seed));
				pnv = 1'($random(seed));
				repeat (5) @(negedge clk);
				eq = 1;
				pq = 1;
				#1 chk("mem ok", 8'(eok), 8'(ee_exp(ea)));
				chk("pot ok", 8'(pok), 8'(write_enable_latch && lk == 0 && !(pnv && wp)));
				@(negedge clk);
				eq = 0;
				pq = 0;
			end
			@(negedge clk) wp = 0;
			cr(DATA_UNLOCK);
			@(negedge clk) ea = 8'hFF;
			eq = 1;
			@(negedge clk) eq = 0;
			unl = (lk == LOCK_NONE);
			repeat (4) @(negedge clk);
			chk("locked try", img, im());
		end
		$display("test lock done");
		cr(DATA_WEL_CLR);
		bad(7'h50, CR_OFFSET, 1, 4'h0);
		bad(CR_DEV_ADDR, 8'hFE, 1, 4'h8);
		bad(CR_DEV_ADDR, CR_OFFSET, 2, 4'hE);
		$display("test frames done");
		@(negedge clk) rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		{write_enable_latch, unl, m2, m3} = 4'h0;
		repeat (4) @(negedge clk);
		chk("reset image", img, im());
		hold_chk();
		$display("test reset done");
		end_sim();
	end
	// long enough for every store and frame with margin
	initial begin
		#450_000;
		err_total++;
		end_sim();
	end
endmodule // scsr_control_status_tb

// *** scsr_host_model.sv ***
`timescale 1ns/1ps
module scsr_host_model (
	// device side of the data line
	input wire logic dev_oe_i,
	input wire logic dev_sda_i,
	// bus pins
	output logic scl_o,
	output logic sda_o
);
	// ==========================================================
	// open-drain line, pull-up wins when nobody pulls
	logic drv = 1'b1;
	int lag = 0;
	assign sda_o = drv & !(dev_oe_i & !dev_sda_i);
	initial scl_o = 1'b1;

	// data moves well after scl falls: no false start or stop
	task automatic bit_io(input logic b, output logic ak);
		#(6 + lag) drv = b;
		#18 scl_o = 1'b1;
		#12 ak = !sda_o;
		#12 scl_o = 1'b0;
	endtask

	task automatic tx_byte(input logic [7:0] b, output logic ak);
		logic x;
		for (int i = 7; i >= 0; i--) bit_io(b[i], x);
		bit_io(1'b1, ak);
	endtask

	task automatic xfer(input logic [6:0] dv, input logic [7:0] ad,
		input logic [15:0] dat, input int nd, output logic [3:0] ak);
		ak = 4'h0;
		#12 drv = 1'b0;
		#12 scl_o = 1'b0;
		tx_byte({dv, 1'b0}, ak[3]);
		tx_byte(ad, ak[2]);
		tx_byte(dat[15:8], ak[1]);
		if (nd > 1) tx_byte(dat[7:0], ak[0]);
		#6 drv = 1'b0;
		#18 scl_o = 1'b1;
		#24 drv = 1'b1;
		#24;
	endtask
endmodule // scsr_host_model

// *** scsr_nv_cell.sv ***
`timescale 1ns/1ps
module scsr_nv_cell import scsr_pkg::*; #(
	parameter int NV_CYC = NV_CYCLE_CYC
) (
	// clock and factory init
	input wire logic core_clk_i,
	input wire logic factory_init_i,
	// store request
	input wire logic wr_i,
	input scsr_nv_s wr_data_i,
	// state
	output scsr_nv_s nv_o,
	output logic busy_o
);

	// ==========================================================
	// storage
	// not touched by sys reset: models cells kept across power loss
	scsr_nv_s nv_r;
	scsr_nv_s stage_r;
	logic busy_r;
	logic [31:0] cnt_r;
	wire logic cyc_done = (cnt_r == 32'(NV_CYC - 1));

	always_ff @(posedge core_clk_i) begin
		if (factory_init_i) begin
			nv_r <= NV_FACTORY;
			stage_r <= NV_FACTORY;
			busy_r <= 1'b0;
			cnt_r <= 32'h0;
		end else if (busy_r) begin
			cnt_r <= cnt_r + 32'h1;
			if (cyc_done) begin
				nv_r <= stage_r;
				busy_r <= 1'b0;
			end
		end else if (wr_i) begin
			stage_r <= wr_data_i;
			busy_r <= 1'b1;
			cnt_r <= 32'h0;
		end
	end

	assign nv_o = nv_r;
	assign busy_o = busy_r;

endmodule // scsr_nv_cell

// *** scsr_pkg.sv ***
package scsr_pkg;

	// ==========================================================
	// clock and times
	localparam int CLK_KHZ = 200000;
	localparam int T_NV_CYCLE_MS = 5;
	localparam int T_HOLD_50_MS = 50;
	localparam int T_HOLD_100_MS = 100;
	localparam int T_HOLD_200_MS = 200;
	localparam int T_HOLD_300_MS = 300;
	localparam int NV_CYCLE_CYC = T_NV_CYCLE_MS * CLK_KHZ;
	localparam int HOLD_50_CYC = T_HOLD_50_MS * CLK_KHZ;
	localparam int HOLD_100_CYC = T_HOLD_100_MS * CLK_KHZ;
	localparam int HOLD_200_CYC = T_HOLD_200_MS * CLK_KHZ;
	localparam int HOLD_300_CYC = T_HOLD_300_MS * CLK_KHZ;

	// ==========================================================
	// serial addressing and command bytes
	localparam logic [6:0] CR_DEV_ADDR = 7'h52;
	localparam logic [7:0] CR_OFFSET = 8'hFF;
	localparam logic [7:0] DATA_WEL_SET = 8'h02;
	localparam logic [7:0] DATA_WEL_CLR = 8'h00;
	localparam logic [7:0] DATA_UNLOCK = 8'h06;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ==========================================================
	// control_status bit positions
	localparam int BIT_DLY_HI = 7;
	localparam int BIT_MON2 = 6;
	localparam int BIT_MON3 = 5;
	localparam int BIT_LOCK_HI = 4;
	localparam int BIT_LOCK_LO = 3;
	localparam int BIT_UNLOCK = 2;
	localparam int BIT_WEL = 1;
	localparam int BIT_DLY_LO = 0;

	// ==========================================================
	// lock field codes and protected region bases
	localparam logic [1:0] LOCK_NONE = 2'h0;
	localparam logic [1:0] LOCK_QUARTER = 2'h1;
	localparam logic [1:0] LOCK_HALF = 2'h2;
	localparam logic [1:0] LOCK_ALL = 2'h3;
	localparam logic [7:0] REGION_QUARTER = 8'hC0;
	localparam logic [7:0] REGION_HALF = 8'h80;

	// ==========================================================
	// reset delay codes and factory values
	localparam logic [1:0] DLY_50 = 2'h0;
	localparam logic [1:0] DLY_100 = 2'h1;
	localparam logic [1:0] DLY_200 = 2'h2;
	localparam logic [1:0] DLY_300 = 2'h3;

	typedef struct packed {
		logic [1:0] reset_delay;
		logic [1:0] lock_field;
	} scsr_nv_s;

	localparam scsr_nv_s NV_FACTORY = '{reset_delay: DLY_100,
		lock_field: LOCK_NONE};

	typedef enum logic [2:0] {
		ACT_NONE,
		ACT_WEL_SET,
		ACT_WEL_CLR,
		ACT_UNLOCK,
		ACT_UNLOCK_ONLY,
		ACT_FULL
	} scsr_act_e;

endpackage
